// ### hw/acpd_pkg.sv
// Package: register map, field positions, encodings and reset values of the converter config bank
package acpd_pkg;
  localparam logic [7:0] ADDR_SOFT_RESET   = 8'h00;
  localparam logic [7:0] ADDR_IF_CONFIG    = 8'h07;
  localparam logic [7:0] ADDR_BLOCK_PDN    = 8'h08;
  localparam logic [7:0] ADDR_BUF_PDN      = 8'h09;
  localparam logic [7:0] ADDR_SLEEP_MASK   = 8'h0D;
  localparam logic [7:0] ADDR_FUSE_LOAD    = 8'h13;

  localparam logic [7:0] RST_VALUE         = 8'h00;
  // Writable bit masks per register; the rest read zero
  localparam logic [7:0] MASK_SOFT_RESET   = 8'h01;
  localparam logic [7:0] MASK_IF_CONFIG    = 8'hEF;
  localparam logic [7:0] MASK_BLOCK_PDN    = 8'h37;
  localparam logic [7:0] MASK_BUF_PDN      = 8'h3F;
  localparam logic [7:0] MASK_SLEEP        = 8'h0E;

  localparam int BIT_SOFT_RESET  = 0;
  localparam int BIT_FUSE_LOAD   = 0;
  localparam int MAP_LSB         = 5;
  localparam int OVR_EN_BIT      = 3;
  localparam int SEL_LSB         = 0;
  localparam int CLKBUF_BIT      = 5;
  localparam int REFAMP_BIT      = 4;
  localparam int CHA_BIT         = 2;
  localparam int CHB_BIT         = 1;
  localparam int SLEEP_BIT       = 0;
  localparam int FRAME_CLOCK_BUF_BIT    = 5;
  localparam int BIT_CLOCK_BUF_BIT    = 4;
  localparam int KEEP_CLKBUF_BIT = 3;
  localparam int KEEP_REFAMP_BIT = 2;
  localparam int BG_OFF_BIT      = 1;

  // Lane mapping codes
  typedef enum logic [2:0] {
    ACPD_MAP_NONE    = 3'h0,
    ACPD_MAP_2W_18   = 3'h1,
    ACPD_MAP_2W_16   = 3'h2,
    ACPD_MAP_1W      = 3'h3,
    ACPD_MAP_HALF    = 3'h4
  } acpd_map_t;

  // Wire mode codes
  typedef enum logic [2:0] {
    ACPD_WIRE_NONE   = 3'h0,
    ACPD_WIRE_2W     = 3'h3,
    ACPD_WIRE_1W     = 3'h4,
    ACPD_WIRE_HALF   = 3'h5
  } acpd_wire_t;

  // Frame phases of the serial control port
  typedef enum logic [1:0] {
    ACPD_S_ADDR = 2'b00,
    ACPD_S_DATA = 2'b01,
    ACPD_S_DONE = 2'b10
  } acpd_spi_state_t;

  localparam int FRAME_BITS = 8;
endpackage : acpd_pkg

// ### hw/acpd_spi_port.sv
// Serial control port: 16-bit frames, R/W flag + 7-bit address, then 8 data bits
`timescale 1ns/100ps
module acpd_spi_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sen_n,
  input  wire logic       spi_sdio_in,
  output logic            spi_sdout,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  // Two-flop synchronisers for all pins; first stage read only by second
  logic [1:0] sclk_s_q, sen_s_q, sdi_s_q;
  logic       sclk_d1_q;
  logic [1:0] sclk_s_d, sen_s_d, sdi_s_d;
  logic       sclk_d1_d;
  always_comb begin
    sclk_s_d  = {sclk_s_q[0], spi_sclk};
    sen_s_d   = {sen_s_q[0], spi_sen_n};
    sdi_s_d   = {sdi_s_q[0], spi_sdio_in};
    sclk_d1_d = sclk_s_q[1];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s_q  <= 2'h0; // Idle level of the serial clock, so no false edge follows reset
      sen_s_q   <= 2'h3;
      sdi_s_q   <= 2'h0;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_s_q  <= sclk_s_d;
      sen_s_q   <= sen_s_d;
      sdi_s_q   <= sdi_s_d;
      sclk_d1_q <= sclk_d1_d;
    end
  end

  logic rise, fall, active;
  assign rise   = sclk_s_q[1] & ~sclk_d1_q;
  assign fall   = ~sclk_s_q[1] & sclk_d1_q;
  assign active = ~sen_s_q[1];

  acpd_pkg::acpd_spi_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d, tx_q, tx_d, wdat_q, wdat_d;
  logic       rdn_q, rdn_d, stb_q, stb_d, so_q, so_d;

  // Frame decode: address byte, then data byte; write on last data bit
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    addr_d = addr_q;
    rdn_d  = rdn_q;
    tx_d   = tx_q;
    wdat_d = wdat_q;
    so_d   = so_q;
    stb_d  = 1'b0;
    if (!active) begin
      st_d  = acpd_pkg::ACPD_S_ADDR;
      cnt_d = 3'h0;
    end else begin
      if (rise && st_q != acpd_pkg::ACPD_S_DONE) begin
        sh_d  = {sh_q[6:0], sdi_s_q[1]};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          unique case (st_q)
            acpd_pkg::ACPD_S_ADDR: begin
              rdn_d  = sh_q[6];
              addr_d = {1'b0, sh_q[5:0], sdi_s_q[1]};
              st_d   = acpd_pkg::ACPD_S_DATA;
            end
            acpd_pkg::ACPD_S_DATA: begin
              wdat_d = {sh_q[6:0], sdi_s_q[1]};
              stb_d  = ~rdn_q;
              st_d   = acpd_pkg::ACPD_S_DONE;
            end
            default: st_d = acpd_pkg::ACPD_S_DONE;
          endcase
        end
      end
      // Read data loads on the fall after the address byte, shifts out MSB first
      if (fall) begin
        if (st_q == acpd_pkg::ACPD_S_DATA && cnt_q == 3'h0) begin
          so_d = rd_data[7];
          tx_d = {rd_data[6:0], 1'b0};
        end else begin
          so_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= acpd_pkg::ACPD_S_ADDR;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      addr_q <= 8'h00;
      rdn_q  <= 1'b0;
      tx_q   <= 8'h00;
      wdat_q <= 8'h00;
      so_q   <= 1'b0;
      stb_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      rdn_q  <= rdn_d;
      tx_q   <= tx_d;
      wdat_q <= wdat_d;
      so_q   <= so_d;
      stb_q  <= stb_d;
    end
  end
  assign spi_sdout = so_q;
  assign wr_stb    = stb_q;
  assign wr_addr   = addr_q;
  assign wr_data   = wdat_q;
  assign rd_addr   = addr_q;
endmodule : acpd_spi_port

// ### hw/acpd_regs.sv
// Configuration and power-down register bank of a dual-channel converter
`timescale 1ns/100ps
// Summary of operation
// - Writing one to bit 0 at address 0x00 restores every register to default and the bit clears itself.
// - Lane mapping 001 is 2-wire 18/14-bit, 010 2-wire 16-bit, 011 1-wire, 100 half-wire; others unused.
// - A lane mapping takes effect only when a fuse load is issued through bit 0 of register 0x13.
// - After reset the fuse default mapping applies while the field reads 000 until written.
// - Bit 3 enables the wire-mode override; bits 2 to 0 replace the default only while it is set.
// - Wire mode 011 is 2-wire, 100 1-wire, 101 half-wire; others unused.
// - After reset the fuse default wire mode applies while the select field reads 000 until written.
// - Bit 5 of 0x08 powers down the sampling clock buffer.
// - Bit 4 of 0x08 disables the reference gain amplifier.
// - Bit 2 of 0x08 powers down channel A and bit 1 channel B.
// - Bit 0 of 0x08 enters global sleep, with blocks chosen by the mask at 0x0D.
// - In 0x09 bit 5 turns off the frame clock buffer, bit 4 the bit clock buffer, bits 3 to 0 the lane buffers.
// - The channel A lane 1 buffer is never turned off automatically by narrow wire modes.
// - In global sleep the clock buffer turns off unless its keep mask bit is set.
module acpd_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sen_n,
  input  wire logic       spi_sdio_in,
  input  wire logic [2:0] fuse_lane_map,
  input  wire logic [2:0] fuse_wire_mode,
  output logic            spi_sdout,
  output logic [2:0]      lane_bit_mapping,
  output logic [2:0]      wire_mode,
  output logic            sample_clock_buffer_off,
  output logic            reference_amp_off,
  output logic            bandgap_off,
  output logic            channel_a_off,
  output logic            channel_b_off,
  output logic            chip_wide_sleep,
  output logic            frame_clock_buffer_off,
  output logic            bit_clock_buffer_off,
  output logic            chan_a_lane1_buffer_off,
  output logic            chan_a_lane0_buffer_off,
  output logic            chan_b_lane1_buffer_off,
  output logic            chan_b_lane0_buffer_off
);
  logic       wr_stb;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [7:0] rd_data;
  logic       sdout_w;

  acpd_spi_port u_spi (
    .clk        (clk),
    .rst        (rst),
    .spi_sclk   (spi_sclk),
    .spi_sen_n  (spi_sen_n),
    .spi_sdio_in(spi_sdio_in),
    .spi_sdout  (sdout_w),
    .wr_stb     (wr_stb),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data)
  );

  // Software-visible registers
  logic [7:0] if_cfg_q, if_cfg_d, blk_q, blk_d, buf_q, buf_d, mask_q, mask_d;
  // Effective interface settings, latched from fuses or the register
  logic [2:0] map_eff_q, map_eff_d, wire_eff_q, wire_eff_d;
  // Fuse defaults are caught at the first edge after reset release, from already settled synchronisers
  logic       fuse_pend_q, fuse_pend_d;
  logic [2:0] fmap_s1_q, fmap_s2_q, fwire_s1_q, fwire_s2_q;

  // Pins from the fuse block are treated as asynchronous; no reset here, so the
  // synchronisers already hold the fuse values when reset lets go and the first
  // default load cannot pick up a cleared stage
  always_ff @(posedge clk) begin
    fmap_s1_q  <= fuse_lane_map;
    fmap_s2_q  <= fmap_s1_q;
    fwire_s1_q <= fuse_wire_mode;
    fwire_s2_q <= fwire_s1_q;
  end

  logic soft_rst, fuse_load;
  assign soft_rst  = wr_stb && wr_addr == acpd_pkg::ADDR_SOFT_RESET && wr_data[acpd_pkg::BIT_SOFT_RESET];
  assign fuse_load = wr_stb && wr_addr == acpd_pkg::ADDR_FUSE_LOAD && wr_data[acpd_pkg::BIT_FUSE_LOAD];

  // Register writes; soft reset and fuse load clear the port settings
  always_comb begin
    if_cfg_d    = if_cfg_q;
    blk_d       = blk_q;
    buf_d       = buf_q;
    mask_d      = mask_q;
    map_eff_d   = map_eff_q;
    wire_eff_d  = wire_eff_q;
    fuse_pend_d = 1'b0;
    if (soft_rst) begin
      // Reset bit itself is never stored, so it reads back as zero
      if_cfg_d    = acpd_pkg::RST_VALUE;
      blk_d       = acpd_pkg::RST_VALUE;
      buf_d       = acpd_pkg::RST_VALUE;
      mask_d      = acpd_pkg::RST_VALUE;
      fuse_pend_d = 1'b1;
    end else if (fuse_load) begin
      // Load keeps only the interface register, others return to default
      blk_d     = acpd_pkg::RST_VALUE;
      buf_d     = acpd_pkg::RST_VALUE;
      mask_d    = acpd_pkg::RST_VALUE;
      map_eff_d = (if_cfg_q[acpd_pkg::MAP_LSB +: 3] == acpd_pkg::ACPD_MAP_NONE)
                  ? fmap_s2_q : if_cfg_q[acpd_pkg::MAP_LSB +: 3];
    end else if (wr_stb) begin
      unique case (wr_addr)
        acpd_pkg::ADDR_IF_CONFIG:  if_cfg_d = wr_data & acpd_pkg::MASK_IF_CONFIG;
        acpd_pkg::ADDR_BLOCK_PDN:  blk_d    = wr_data & acpd_pkg::MASK_BLOCK_PDN;
        acpd_pkg::ADDR_BUF_PDN:    buf_d    = wr_data & acpd_pkg::MASK_BUF_PDN;
        acpd_pkg::ADDR_SLEEP_MASK: mask_d   = wr_data & acpd_pkg::MASK_SLEEP;
        default: ;
      endcase
    end
    if (fuse_pend_q) begin
      map_eff_d  = fmap_s2_q;
      wire_eff_d = fwire_s2_q;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      if_cfg_q    <= acpd_pkg::RST_VALUE;
      blk_q       <= acpd_pkg::RST_VALUE;
      buf_q       <= acpd_pkg::RST_VALUE;
      mask_q      <= acpd_pkg::RST_VALUE;
      map_eff_q   <= 3'h0;
      wire_eff_q  <= 3'h0;
      fuse_pend_q <= 1'b1;
    end else begin
      if_cfg_q    <= if_cfg_d;
      blk_q       <= blk_d;
      buf_q       <= buf_d;
      mask_q      <= mask_d;
      map_eff_q   <= map_eff_d;
      wire_eff_q  <= wire_eff_d;
      fuse_pend_q <= fuse_pend_d;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      acpd_pkg::ADDR_IF_CONFIG:  rd_data = if_cfg_q;
      acpd_pkg::ADDR_BLOCK_PDN:  rd_data = blk_q;
      acpd_pkg::ADDR_BUF_PDN:    rd_data = buf_q;
      acpd_pkg::ADDR_SLEEP_MASK: rd_data = mask_q;
      default:                   rd_data = acpd_pkg::RST_VALUE;
    endcase
  end

  // Wire mode: override only while enabled with a used code, else fuse default
  function automatic logic wire_code_used(input logic [2:0] c);
    wire_code_used = (c == acpd_pkg::ACPD_WIRE_2W) || (c == acpd_pkg::ACPD_WIRE_1W) ||
                     (c == acpd_pkg::ACPD_WIRE_HALF);
  endfunction : wire_code_used

  logic [2:0] sel;
  logic       sleep;
  assign sel   = if_cfg_q[acpd_pkg::SEL_LSB +: 3];
  assign sleep = blk_q[acpd_pkg::SLEEP_BIT];

  logic [15:0] out_d, out_q;
  // Power-down outputs; sleep gated by the keep mask for the clock buffer and reference amp
  always_comb begin
    out_d[2:0]  = (if_cfg_q[acpd_pkg::OVR_EN_BIT] && wire_code_used(sel)) ? sel : wire_eff_q;
    out_d[5:3]  = map_eff_q;
    out_d[6]    = blk_q[acpd_pkg::CLKBUF_BIT] | (sleep & ~mask_q[acpd_pkg::KEEP_CLKBUF_BIT]);
    out_d[7]    = blk_q[acpd_pkg::REFAMP_BIT] | (sleep & ~mask_q[acpd_pkg::KEEP_REFAMP_BIT]);
    out_d[8]    = sleep & mask_q[acpd_pkg::BG_OFF_BIT];
    out_d[9]    = blk_q[acpd_pkg::CHA_BIT] | sleep;
    out_d[10]   = blk_q[acpd_pkg::CHB_BIT] | sleep;
    out_d[11]   = sleep;
    out_d[15:12] = {buf_q[acpd_pkg::FRAME_CLOCK_BUF_BIT], buf_q[acpd_pkg::BIT_CLOCK_BUF_BIT],
                    buf_q[3], buf_q[2]};
  end
  logic [1:0] bl_d, bl_q;
  assign bl_d = buf_q[1:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q     <= 16'h0000;
      bl_q      <= 2'h0;
      spi_sdout <= 1'b0;
    end else begin
      out_q     <= out_d;
      bl_q      <= bl_d;
      spi_sdout <= sdout_w;
    end
  end
  assign wire_mode               = out_q[2:0];
  assign lane_bit_mapping        = out_q[5:3];
  assign sample_clock_buffer_off = out_q[6];
  assign reference_amp_off       = out_q[7];
  assign bandgap_off             = out_q[8];
  assign channel_a_off           = out_q[9];
  assign channel_b_off           = out_q[10];
  assign chip_wide_sleep         = out_q[11];
  assign frame_clock_buffer_off  = out_q[15];
  assign bit_clock_buffer_off    = out_q[14];
  assign chan_a_lane1_buffer_off = out_q[13];
  assign chan_a_lane0_buffer_off = out_q[12];
  assign chan_b_lane1_buffer_off = bl_q[1];
  assign chan_b_lane0_buffer_off = bl_q[0];
endmodule : acpd_regs

// ### dv/acpd_spi_host.sv
// Serial control port host model driving the config bank frames
`timescale 1ns/100ps
module acpd_spi_host (
  input  wire logic clk,
  output logic      spi_sclk,
  output logic      spi_sen_n,
  output logic      spi_sdio_in,
  input  wire logic spi_sdout
);
  localparam int HALF = 5; // Serial half period in clk cycles, above the 4 the port needs

  // Idle: clock stands low and no frame is selected
  initial begin
    spi_sclk = 1'b0;
    spi_sen_n = 1'b1;
    spi_sdio_in = 1'b0;
  end

  // One 16-bit frame: direction flag, 7-bit address, 8 data bits, MSB first
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {rw, addr, wd};
    rdat = 8'h00;
    @(posedge clk);
    spi_sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdio_in <= frame[i];
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      // Read bits are taken late in the high phase, well after the device shifted on the fall
      if (i < 8) rdat[i] = spi_sdout;
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spi_sen_n <= 1'b1;
    spi_sdio_in <= ~frame[0]; // Released line shows the inverse, never a stale bit
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : acpd_spi_host

// ### dv/acpd_regs_checker.sv
// Port-level assertions for the converter config and power-down bank
`timescale 1ns/100ps
module acpd_regs_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       spi_sen_n,
  input wire logic [2:0] fuse_lane_map,
  input wire logic [2:0] fuse_wire_mode,
  input wire logic [2:0] lane_bit_mapping,
  input wire logic [2:0] wire_mode,
  input wire logic       sample_clock_buffer_off,
  input wire logic       reference_amp_off,
  input wire logic       bandgap_off,
  input wire logic       channel_a_off,
  input wire logic       channel_b_off,
  input wire logic       chip_wide_sleep,
  input wire logic       frame_clock_buffer_off,
  input wire logic       bit_clock_buffer_off,
  input wire logic       chan_a_lane1_buffer_off,
  input wire logic       chan_a_lane0_buffer_off,
  input wire logic       chan_b_lane1_buffer_off,
  input wire logic       chan_b_lane0_buffer_off
);
  logic [3:0]  idle_q;
  logic [3:0]  idle_d;
  logic [17:0] outs;
  default clocking cb @(posedge clk);
  endclocking

  // All control outputs in one vector, so stability is a single check
  assign outs = {lane_bit_mapping, wire_mode, sample_clock_buffer_off, reference_amp_off, bandgap_off,
                 channel_a_off, channel_b_off, chip_wide_sleep, frame_clock_buffer_off, bit_clock_buffer_off,
                 chan_a_lane1_buffer_off, chan_a_lane0_buffer_off, chan_b_lane1_buffer_off,
                 chan_b_lane0_buffer_off};

  // Idle cycles since the last frame; saturates so a long pause never wraps
  always_comb begin
    idle_d = idle_q;
    if (rst || !spi_sen_n) idle_d = 4'h0;
    else if (idle_q != 4'hF) idle_d = idle_q + 4'h1;
  end
  always_ff @(posedge clk) begin
    idle_q <= idle_d;
  end

  sequence rel_s;
    $fell(rst);
  endsequence
  sequence fuse_s;
    lane_bit_mapping == fuse_lane_map && wire_mode == fuse_wire_mode;
  endsequence

  reset_clears_a: assert property (rst |=> outs == 18'h0)
    else $error("outputs not cleared in reset");
  fuse_default_a: assert property (disable iff (rst) rel_s |-> ##[1:4] fuse_s)
    else $error("fuse defaults not applied");
  idle_stable_a: assert property (disable iff (rst) idle_q == 4'hF |-> $stable(outs))
    else $error("output moved with no frame");
  map_legal_a: assert property (disable iff (rst) lane_bit_mapping <= 3'h4 || lane_bit_mapping == fuse_lane_map)
    else $error("unused lane mapping code");
  wire_legal_a: assert property (disable iff (rst)
    wire_mode inside {3'h0, 3'h3, 3'h4, 3'h5} || wire_mode == fuse_wire_mode)
    else $error("unused wire mode code");
  sleep_chan_a: assert property (disable iff (rst) chip_wide_sleep |-> channel_a_off && channel_b_off)
    else $error("channels on in sleep");
  bandgap_sleep_a: assert property (disable iff (rst) bandgap_off |-> chip_wide_sleep)
    else $error("bandgap off outside sleep");
  lane1_kept_a: assert property (disable iff (rst) $changed(wire_mode) && wire_mode inside {3'h4, 3'h5}
    |-> $stable({chan_a_lane1_buffer_off, chan_b_lane1_buffer_off}))
    else $error("lane 1 buffer changed by wire mode");
endmodule : acpd_regs_checker

bind acpd_regs acpd_regs_checker acpd_regs_checker_inst (
  .clk(clk), .rst(rst), .spi_sen_n(spi_sen_n), .fuse_lane_map(fuse_lane_map),
  .fuse_wire_mode(fuse_wire_mode), .lane_bit_mapping(lane_bit_mapping), .wire_mode(wire_mode),
  .sample_clock_buffer_off(sample_clock_buffer_off), .reference_amp_off(reference_amp_off),
  .bandgap_off(bandgap_off), .channel_a_off(channel_a_off), .channel_b_off(channel_b_off),
  .chip_wide_sleep(chip_wide_sleep), .frame_clock_buffer_off(frame_clock_buffer_off),
  .bit_clock_buffer_off(bit_clock_buffer_off), .chan_a_lane1_buffer_off(chan_a_lane1_buffer_off),
  .chan_a_lane0_buffer_off(chan_a_lane0_buffer_off), .chan_b_lane1_buffer_off(chan_b_lane1_buffer_off),
  .chan_b_lane0_buffer_off(chan_b_lane0_buffer_off));

// ### dv/tb_top.sv
// Self-checking bench for the converter config and power-down bank
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] FUSE_MAP  = 3'h2; // Fuse defaults of our choosing, both legal codes
  localparam logic [2:0] FUSE_WIRE = 3'h3;
  localparam logic [7:0] A_RST     = acpd_pkg::ADDR_SOFT_RESET;
  localparam logic [7:0] A_IF      = acpd_pkg::ADDR_IF_CONFIG;
  localparam logic [7:0] A_PDN     = acpd_pkg::ADDR_BLOCK_PDN;
  localparam logic [7:0] A_BUF     = acpd_pkg::ADDR_BUF_PDN;
  localparam logic [7:0] A_MSK     = acpd_pkg::ADDR_SLEEP_MASK;
  localparam logic [7:0] A_FUSE    = acpd_pkg::ADDR_FUSE_LOAD;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  wire logic       spi_sclk;
  wire logic       spi_sen_n;
  wire logic       spi_sdio_in;
  wire logic       spi_sdout;
  wire logic [2:0] lane_bit_mapping;
  wire logic [2:0] wire_mode;
  wire logic [5:0] blk;
  wire logic [5:0] bufp;
  int              err_total = 0;
  int              tests_run = 0;

  always #5 clk = ~clk;

  // Block outputs gathered in register bit order: blk {clk,ref,bandgap,A,B,sleep}, bufp as output_buffer_power_down
  acpd_regs acpd_regs_inst (
    .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n), .spi_sdio_in(spi_sdio_in),
    .fuse_lane_map(FUSE_MAP), .fuse_wire_mode(FUSE_WIRE), .spi_sdout(spi_sdout),
    .lane_bit_mapping(lane_bit_mapping), .wire_mode(wire_mode), .sample_clock_buffer_off(blk[5]),
    .reference_amp_off(blk[4]), .bandgap_off(blk[3]), .channel_a_off(blk[2]), .channel_b_off(blk[1]),
    .chip_wide_sleep(blk[0]), .frame_clock_buffer_off(bufp[5]), .bit_clock_buffer_off(bufp[4]),
    .chan_a_lane1_buffer_off(bufp[3]), .chan_a_lane0_buffer_off(bufp[2]),
    .chan_b_lane1_buffer_off(bufp[1]), .chan_b_lane0_buffer_off(bufp[0]));
  acpd_spi_host acpd_spi_host_inst (.clk(clk), .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdout(spi_sdout));

  task automatic pin_chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : pin_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acpd_spi_host_inst.xfer(1'b0, a[6:0], d, r);
  endtask : wr

  // Readback compare through a full read frame
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    acpd_spi_host_inst.xfer(1'b1, a[6:0], 8'h00, r);
    pin_chk(r, exp, "readback");
  endtask : rd_chk

  task automatic test_defaults();
    pin_chk({2'h0, lane_bit_mapping, wire_mode}, {2'h0, FUSE_MAP, FUSE_WIRE}, "fuse mode");
    rd_chk(A_IF, 8'h00);
    rd_chk(A_PDN, 8'h00);
    rd_chk(A_BUF, 8'h00);
    $display("test defaults done");
  endtask : test_defaults

  // Each map code, loaded by a fuse load; wire codes incl. an unused one
  task automatic test_mapping();
    logic [2:0] wsel [4] = '{3'h3, 3'h4, 3'h5, 3'h1};
    logic [2:0] wexp [4] = '{3'h3, 3'h4, 3'h5, FUSE_WIRE};
    logic [2:0] prev;
    logic [7:0] v;
    prev = FUSE_MAP;
    for (int i = 0; i < 4; i++) begin
      v = {3'(i + 1), 2'b01, wsel[i]};
      wr(A_IF, v);
      pin_chk({2'h0, lane_bit_mapping, wire_mode}, {2'h0, prev, wexp[i]}, "before load");
      wr(A_FUSE, 8'h01);
      prev = 3'(i + 1);
      pin_chk({2'h0, lane_bit_mapping, wire_mode}, {2'h0, prev, wexp[i]}, "after load");
      rd_chk(A_IF, v);
    end
    rd_chk(A_FUSE, 8'h00);
    wr(A_IF, 8'hFF);
    rd_chk(A_IF, 8'hEF);
    wr(A_IF, 8'h04);
    pin_chk({2'h0, lane_bit_mapping, wire_mode}, {2'h0, prev, FUSE_WIRE}, "no override");
    wr(8'h05, 8'hAA);
    rd_chk(8'h05, 8'h00);
    $display("test mapping done");
  endtask : test_mapping

  task automatic test_power();
    logic [7:0] pd [7] = '{8'h20, 8'h10, 8'h04, 8'h02, 8'h01, 8'h01, 8'h01};
    logic [7:0] mk [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h06};
    logic [7:0] p;
    logic [7:0] m;
    wr(A_PDN, 8'h04);
    wr(A_FUSE, 8'h01);
    rd_chk(A_PDN, 8'h00);
    for (int i = 0; i < 7; i++) begin
      p = pd[i];
      m = mk[i];
      wr(A_MSK, m);
      wr(A_PDN, p);
      pin_chk({2'h0, blk}, {2'h0, p[5] | (p[0] & ~m[3]), p[4] | (p[0] & ~m[2]), p[0] & m[1],
              p[2] | p[0], p[1] | p[0], p[0]}, "block power");
    end
    wr(A_PDN, 8'hFF);
    rd_chk(A_PDN, 8'h37);
    wr(A_PDN, 8'h00);
    $display("test power done");
  endtask : test_power

  // Walking one over the buffer bits while in 1-wire mode
  task automatic test_buffers();
    wr(A_IF, 8'h0C);
    wr(A_BUF, 8'h00);
    pin_chk({2'h0, bufp}, 8'h00, "buffers 1-wire");
    for (int i = 0; i < 6; i++) begin
      wr(A_BUF, 8'h01 << i);
      pin_chk({2'h0, bufp}, 8'h01 << i, "buffer bit");
    end
    wr(A_BUF, 8'hFF);
    rd_chk(A_BUF, 8'h3F);
    $display("test buffers done");
  endtask : test_buffers

  task automatic test_soft_reset();
    wr(A_PDN, 8'h24);
    wr(A_RST, 8'h01);
    rd_chk(A_RST, 8'h00);
    rd_chk(A_IF, 8'h00);
    rd_chk(A_PDN, 8'h00);
    pin_chk({2'h0, blk}, 8'h00, "blocks after reset");
    pin_chk({2'h0, bufp}, 8'h00, "buffers after reset");
    pin_chk({2'h0, lane_bit_mapping, wire_mode}, {2'h0, FUSE_MAP, FUSE_WIRE}, "mode after reset");
    $display("test soft reset done");
  endtask : test_soft_reset

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    test_defaults();
    test_mapping();
    test_power();
    test_buffers();
    test_soft_reset();
    final_report();
  end

  // About 60 frames of some 170 cycles each; the limit leaves ample slack
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule : tb_top
